// ---- rtl/program_flash_table_access.sv ----
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pft_regs.svh"
module program_flash_table_access #(
  parameter int AW = 22,
  parameter int BLK = 64,
  parameter int WORDS = 1024
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output logic cpu_stall,
  output logic irq
);
  import pft_pkg::*;
  localparam int BW = $clog2(BLK);
  localparam int LB = $clog2(WORDS) + 1;
  localparam int PROT_W = 8;
  // refuse sizes that the index and row logic cannot serve
  if (BLK < 2 || (BLK & (BLK - 1)) != 0 || AW < LB || AW > 22) begin : g_bad_size
    $error("unsupported block size or address width");
  end

  flash_if #(.AW(AW), .BLK(BLK)) fl ();
  flash_array #(.AW(AW), .BLK(BLK), .WORDS(WORDS)) u_array (
    .clock(clock),
    .rst_n(rst_n),
    .fl(fl)
  );

  addr_t table_pointer;
  byte_t table_latch;
  byte_t hold_r [BLK];
  byte_t prot_r;
  logic go_r, en_r, err_r, sel_r;
  logic [1:0] unlock_r;
  logic done_st_r, err_st_r;
  logic [1:0] mask_r;
  byte_t rdata_r;
  prog_state_e state_r;
  table_op_e op;
  logic wr_ptr_lo, wr_ptr_mid, wr_ptr_hi, wr_latch, wr_ctrl, wr_unlock, wr_cmd;
  logic rd_stat, bad_addr, finish, fail, arm;

  ////////////////////////////////////////////////////////////////////////
  // address decode for register writes and the status read
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  assign wr_ptr_lo = wr_stb && hit(addr, `PFT_OFS_PTR_LO);
  assign wr_ptr_mid = wr_stb && hit(addr, `PFT_OFS_PTR_MID);
  assign wr_ptr_hi = wr_stb && hit(addr, `PFT_OFS_PTR_HI);
  assign wr_latch = wr_stb && hit(addr, `PFT_OFS_LATCH);
  assign wr_ctrl = wr_stb && hit(addr, `PFT_OFS_CTRL);
  assign wr_unlock = wr_stb && hit(addr, `PFT_OFS_UNLOCK);
  assign wr_cmd = wr_stb && hit(addr, `PFT_OFS_CMD);
  assign rd_stat = rd_stb && hit(addr, `PFT_OFS_IRQ_STAT);

  // table operation decode; none while a long write holds the core
  always_comb begin
    op = OP_NONE;
    if (wr_cmd && state_r == ST_IDLE) begin
      if (wdata == `PFT_CMD_READ) begin
        op = OP_READ;
      end else if (wdata == `PFT_CMD_WRITE) begin
        op = OP_WRITE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // byte-addressed table pointer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      table_pointer <= '0;
    end else begin
      if (wr_ptr_lo) table_pointer[7:0] <= wdata;
      if (wr_ptr_mid) table_pointer[15:8] <= wdata;
      if (wr_ptr_hi) table_pointer[21:16] <= wdata[5:0];
    end
  end

  // flash word selected by pointer; the low bit picks the byte
  assign fl.rd_word = table_pointer[AW-1:1];

  // the single byte path between flash, holding registers and data space
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      table_latch <= '0;
    end else if (op == OP_READ) begin
      table_latch <= table_pointer[0] ? fl.rd_data[15:8] : fl.rd_data[7:0];
    end else if (wr_latch) begin
      table_latch <= wdata;
    end
  end

  // holding registers: one per block byte, set to ones after programming
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < BLK; i++) hold_r[i] <= `PFT_HOLD_RST;
    end else if (state_r == ST_DONE) begin
      for (int i = 0; i < BLK; i++) hold_r[i] <= `PFT_HOLD_RST;
    end else if (op == OP_WRITE) begin
      hold_r[table_pointer[BW-1:0]] <= table_latch;
    end
  end

  // whole block handed to the array; no single word path exists
  always_comb begin
    fl.prog_data = '0;
    for (int i = 0; i < BLK; i++) fl.prog_data[i*8 +: 8] = hold_r[i];
  end
  assign fl.prog_row = table_pointer[AW-1:1];
  assign fl.prog_req = (state_r == ST_CHECK) && !bad_addr;

  ////////////////////////////////////////////////////////////////////////
  // protection: region register counts protected 256-word pages from zero
  assign bad_addr = (table_pointer[AW-1:1] >= (AW-1)'(WORDS)) ||
    ((table_pointer[AW-1:9] < (AW-9)'(prot_r)));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prot_r <= `PFT_PROT_RST;
    end else if (wr_stb && hit(addr, `PFT_OFS_PROT)) begin
      prot_r <= wdata[PROT_W-1:0];
    end
  end

  // unlock sequence: key1 then key2 arms one program-go
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      unlock_r <= 2'h0;
    end else if (wr_unlock) begin
      if (wdata == `PFT_KEY1) unlock_r <= 2'h1;
      else if (wdata == `PFT_KEY2 && unlock_r == 2'h1) unlock_r <= 2'h2;
      else unlock_r <= 2'h0;
    end else if (wr_stb) begin
      unlock_r <= 2'h0;
    end
  end

  assign arm = wr_ctrl && wdata[`PFT_CTRL_GO] && en_r && sel_r && unlock_r == 2'h2 &&
    state_r == ST_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // long write sequencer
  assign finish = (state_r == ST_PROG) && !fl.prog_busy;
  assign fail = (state_r == ST_CHECK) && bad_addr;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: if (arm) state_r <= ST_CHECK;
        ST_CHECK: state_r <= bad_addr ? ST_IDLE : ST_PROG;
        ST_PROG: if (!fl.prog_busy) state_r <= ST_DONE;
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // core held from go until the block is done
  assign cpu_stall = (state_r == ST_CHECK) || (state_r == ST_PROG);

  // control register bits; go cleared by hardware at the end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      go_r <= 1'b0;
      en_r <= 1'b0;
      sel_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (wr_ctrl && state_r == ST_IDLE) begin
        en_r <= wdata[`PFT_CTRL_EN];
        sel_r <= wdata[`PFT_CTRL_SEL];
        err_r <= wdata[`PFT_CTRL_ERR];
      end
      if (fail) err_r <= 1'b1;
      if (arm) go_r <= 1'b1;
      else if (fail || finish) go_r <= 1'b0;
    end
  end

  // sticky status, cleared on read; a new event beats the clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_st_r <= 1'b0;
      err_st_r <= 1'b0;
    end else begin
      if (finish) done_st_r <= 1'b1;
      else if (rd_stat) done_st_r <= 1'b0;
      if (fail) err_st_r <= 1'b1;
      else if (rd_stat) err_st_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= 2'h0;
    end else if (wr_stb && hit(addr, `PFT_OFS_IRQ_MASK)) begin
      mask_r <= wdata[1:0];
    end
  end

  assign irq = (done_st_r && mask_r[`PFT_IRQ_DONE]) || (err_st_r && mask_r[`PFT_IRQ_ERR]);

  ////////////////////////////////////////////////////////////////////////
  // read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (rd_stb) begin
      case (addr)
        `PFT_OFS_PTR_LO: rdata_r <= table_pointer[7:0];
        `PFT_OFS_PTR_MID: rdata_r <= table_pointer[15:8];
        `PFT_OFS_PTR_HI: rdata_r <= {2'h0, table_pointer[21:16]};
        `PFT_OFS_LATCH: rdata_r <= table_latch;
        `PFT_OFS_CTRL: rdata_r <= {sel_r, 3'h0, err_r, en_r, 1'b0, go_r};
        `PFT_OFS_IRQ_STAT: rdata_r <= {6'h0, err_st_r, done_st_r};
        `PFT_OFS_IRQ_MASK: rdata_r <= {6'h0, mask_r};
        `PFT_OFS_PROT: rdata_r <= prot_r;
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // helper: every holding register back at its erased value
  logic hold_all_ones;
  always_comb begin
    hold_all_ones = 1'b1;
    for (int i = 0; i < BLK; i++) begin
      if (hold_r[i] != `PFT_HOLD_RST) hold_all_ones = 1'b0;
    end
  end

  // helper: cycles the core has been held so far in this stall
  logic [7:0] stall_cnt_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt_r <= 8'h00;
    end else if (cpu_stall) begin
      stall_cnt_r <= stall_cnt_r + 8'h01;
    end else begin
      stall_cnt_r <= 8'h00;
    end
  end

  // arming: keys, enable and select are all needed for go
  a_go_needs_unlock: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(go_r) |-> $past(unlock_r) == 2'h2)
    else $error("go without unlock");
  a_go_needs_enable: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(go_r) |-> $past(en_r) && $past(sel_r))
    else $error("go without enable");
  a_key_order: assert property (@(posedge clock) disable iff (!rst_n)
    wr_ctrl && wdata[`PFT_CTRL_GO] && unlock_r != 2'h2 && state_r == ST_IDLE |=> !go_r)
    else $error("go armed without keys");
  a_unlock_cleared: assert property (@(posedge clock) disable iff (!rst_n)
    wr_stb && !wr_unlock |=> unlock_r == 2'h0)
    else $error("unlock survived other write");

  // refused pointer: nothing programmed, error raised
  a_bad_sets_err: assert property (@(posedge clock) disable iff (!rst_n)
    fail |=> err_r && !go_r && state_r == ST_IDLE)
    else $error("bad address not flagged");
  a_bad_no_prog: assert property (@(posedge clock) disable iff (!rst_n)
    fail |=> !fl.prog_busy)
    else $error("protected block programmed");
  a_err_status: assert property (@(posedge clock) disable iff (!rst_n)
    fail |=> err_st_r)
    else $error("error status not set");

  // stall spans the check cycle, the timer and the finishing cycle
  a_stall_span: assert property (@(posedge clock) disable iff (!rst_n)
    go_r == cpu_stall)
    else $error("core not stalled");
  a_stall_bound: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(cpu_stall) |-> ##[1:8] !cpu_stall)
    else $error("stall too long");
  a_prog_starts: assert property (@(posedge clock) disable iff (!rst_n)
    fl.prog_req |=> fl.prog_busy)
    else $error("timer not started");
  a_prog_time: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(cpu_stall) && state_r == ST_DONE |-> stall_cnt_r == 8'(`PFT_PROG_CYC + 2))
    else $error("programming time wrong");

  // completion: flag, interrupt and erased holding registers
  a_done_flag: assert property (@(posedge clock) disable iff (!rst_n)
    finish |=> done_st_r && !go_r && en_r == $past(en_r))
    else $error("done not signalled");
  a_irq_mask: assert property (@(posedge clock) disable iff (!rst_n)
    finish && mask_r[`PFT_IRQ_DONE] |=> irq)
    else $error("irq missing when enabled");
  a_done_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    done_st_r && !rd_stat |=> done_st_r)
    else $error("done flag lost");
  a_hold_ones: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_DONE |=> hold_r[0] == 8'hff && hold_r[BLK-1] == 8'hff)
    else $error("holding not reset");
  a_hold_all: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_DONE |=> hold_all_ones)
    else $error("holding block not erased");

  // byte path through the latch
  a_load_no_flag: assert property (@(posedge clock) disable iff (!rst_n)
    op == OP_WRITE |=> hold_r[$past(table_pointer[BW-1:0])] == $past(table_latch) &&
    done_st_r == $past(done_st_r))
    else $error("holding load wrong");
  a_read_byte: assert property (@(posedge clock) disable iff (!rst_n)
    op == OP_READ |=> table_latch == ($past(table_pointer[0]) ? $past(fl.rd_data[15:8]) :
    $past(fl.rd_data[7:0])))
    else $error("table read wrong");
  a_latch_steady: assert property (@(posedge clock) disable iff (!rst_n)
    !wr_latch && op != OP_READ |=> table_latch == $past(table_latch))
    else $error("latch changed unasked");
  a_ptr_byte: assert property (@(posedge clock) disable iff (!rst_n)
    wr_ptr_lo |=> table_pointer[7:0] == $past(wdata))
    else $error("pointer byte not taken");
  a_read_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !rd_stb |=> rdata == 8'h00)
    else $error("read data outside its cycle");

  c_prog: cover property (@(posedge clock) disable iff (!rst_n) finish);
  c_fail: cover property (@(posedge clock) disable iff (!rst_n) fail);
  c_read: cover property (@(posedge clock) disable iff (!rst_n) op == OP_READ);
  c_load: cover property (@(posedge clock) disable iff (!rst_n) op == OP_WRITE);
  c_irq: cover property (@(posedge clock) disable iff (!rst_n) irq);
endmodule
`default_nettype wire

// ---- rtl/pft_regs.svh ----
`ifndef PFT_REGS_SVH
`define PFT_REGS_SVH
// register offsets (byte addresses on the plain port)
`define PFT_OFS_PTR_LO 8'h00
`define PFT_OFS_PTR_MID 8'h04
`define PFT_OFS_PTR_HI 8'h08
`define PFT_OFS_LATCH 8'h0c
`define PFT_OFS_CTRL 8'h10
`define PFT_OFS_UNLOCK 8'h14
`define PFT_OFS_CMD 8'h18
`define PFT_OFS_IRQ_STAT 8'h1c
`define PFT_OFS_IRQ_MASK 8'h20
`define PFT_OFS_PROT 8'h24
// control register fields
`define PFT_CTRL_GO 0
`define PFT_CTRL_EN 2
`define PFT_CTRL_ERR 3
`define PFT_CTRL_SEL 7
// command codes
`define PFT_CMD_READ 8'h01
`define PFT_CMD_WRITE 8'h02
// unlock keys
`define PFT_KEY1 8'h55
`define PFT_KEY2 8'haa
// interrupt status fields
`define PFT_IRQ_DONE 0
`define PFT_IRQ_ERR 1
// reset values
`define PFT_HOLD_RST 8'hff
`define PFT_PROT_RST 8'h00
// timing: programming time and cycle count at 10 MHz
`define PFT_CLK_MHZ 10
`define PFT_PROG_TIME_NS 100
`define PFT_PROG_CYC ((`PFT_PROG_TIME_NS * `PFT_CLK_MHZ + 999) / 1000)
`endif

// ---- rtl/pft_pkg.sv ----
package pft_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [21:0] addr_t;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_READ,
    OP_WRITE
  } table_op_e;
  typedef enum {
    ST_IDLE,
    ST_CHECK,
    ST_PROG,
    ST_DONE
  } prog_state_e;
endpackage

// ---- rtl/flash_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// program flash array port between the controller and the array model
interface flash_if #(parameter int AW = 22, parameter int BLK = 64);
  logic [AW-2:0] rd_word;
  logic [15:0] rd_data;
  logic prog_req;
  logic [AW-2:0] prog_row;
  logic [BLK*8-1:0] prog_data;
  logic prog_busy;
  modport ctrl (output rd_word, input rd_data, output prog_req, output prog_row,
    output prog_data, input prog_busy);
  modport array (input rd_word, output rd_data, input prog_req, input prog_row,
    input prog_data, output prog_busy);
endinterface
`default_nettype wire

// ---- rtl/flash_array.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pft_regs.svh"
// word-wide program flash array with a block programming timer
module flash_array #(
  parameter int AW = 22,
  parameter int BLK = 64,
  parameter int WORDS = 1024
) (
  input wire logic clock,
  input wire logic rst_n,
  flash_if.array fl
);
  import pft_pkg::*;
  localparam int WB = BLK / 2;
  localparam int LW = $clog2(WORDS);
  localparam int PCW = $clog2(`PFT_PROG_CYC + 1);
  localparam logic [PCW-1:0] PROG_CYC = PCW'(`PFT_PROG_CYC);
  logic [15:0] mem [WORDS];
  logic [PCW-1:0] timer_r;
  logic busy_r;
  logic [15:0] rd_r;

  ////////////////////////////////////////////////////////////////////////
  // asynchronous word read
  assign fl.rd_data = mem[fl.rd_word[LW-1:0]];
  assign fl.prog_busy = busy_r;

  // internal programming timer sets the write time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_r <= '0;
      busy_r <= 1'b0;
    end else if (fl.prog_req && !busy_r) begin
      timer_r <= PROG_CYC;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      timer_r <= timer_r - PCW'(1);
      busy_r <= (timer_r != PCW'(1));
    end
  end

  // whole block written at the start of a programming cycle
  always_ff @(posedge clock) begin
    if (fl.prog_req && !busy_r) begin
      for (int i = 0; i < WB; i++) begin
        mem[(fl.prog_row[LW-1:0] & ~LW'(WB - 1)) | LW'(i)] <=
          fl.prog_data[i*16 +: 16];
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pft_regs.svh"
// processor side: issues register writes and reads on the plain port
module core_model
  import pft_pkg::*;
(
  input wire logic clock,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr_stb,
  output logic rd_stb
);
  import pft_pkg::*;
  byte_t exp_q[$];
  // idle bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one-cycle write; strobe stays up across back-to-back writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    rd_stb <= 1'b0;
    wr_stb <= 1'b1;
    @(posedge clock);
  endtask
  // one-cycle read; the expected answer is noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
  endtask
  task automatic idle();
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    @(posedge clock);
  endtask
  // keys then control write with no other write between them
  task automatic unlock_go(input logic [7:0] ctl);
    wr(`PFT_OFS_UNLOCK, `PFT_KEY1);
    wr(`PFT_OFS_UNLOCK, `PFT_KEY2);
    wr(`PFT_OFS_CTRL, ctl);
  endtask
endmodule
`default_nettype wire

// ---- tb/program_flash_table_access_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pft_regs.svh"
module program_flash_table_access_bench;
  import pft_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  wire logic [7:0] addr;
  wire logic [7:0] wdata;
  wire logic wr_stb;
  wire logic rd_stb;
  logic [7:0] rdata;
  logic cpu_stall;
  logic irq;
  logic rd_d = 1'b0;
  int fails = 0;
  int num_checks = 0;
  int seed = 3;
  byte_t mem [64];
  // 10 MHz system clock
  always #50 clock = ~clock;
  program_flash_table_access dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cpu_stall(cpu_stall), .irq(irq));
  core_model core (.clock(clock), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // read data stand only in the cycle after the read strobe
  always @(posedge clock) begin
    if (rd_d) begin
      if (core.exp_q.size() == 0) begin
        check(rdata, ~rdata);
      end else begin
        check(rdata, core.exp_q.pop_front());
      end
    end
    rd_d <= rd_stb;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic set_ptr(input addr_t p);
    core.wr(`PFT_OFS_PTR_LO, p[7:0]);
    core.wr(`PFT_OFS_PTR_MID, p[15:8]);
    core.wr(`PFT_OFS_PTR_HI, {2'b00, p[21:16]});
  endtask
  // long write: stall rises after the control write and falls within a bound
  task automatic long_write();
    int i;
    core.unlock_go(8'h85);
    // stall may last one cycle only, so look during the idle cycle that follows
    fork
      core.idle();
      begin
        #1;
        check({7'h00, cpu_stall}, 8'h01);
      end
    join
    #1;
    for (i = 0; i < 50 && cpu_stall !== 1'b0; i++) begin
      @(posedge clock);
      #1;
    end
    if (i == 50) begin
      fails++;
      end_sim();
    end
  endtask
  initial begin
    int i;
    repeat (3) @(posedge clock);
    check({6'h00, cpu_stall, irq}, 8'h00);
    rst_n <= 1'b1;
    @(posedge clock);
    core.wr(`PFT_OFS_IRQ_MASK, 8'h03);
    core.wr(`PFT_OFS_PROT, 8'h01);
    set_ptr(22'h000040);
    // fill one block through the latch while it sits in a protected area
    for (i = 0; i < 64; i++) begin
      mem[i] = 8'($random(seed));
      core.wr(`PFT_OFS_PTR_LO, 8'h40 + i[7:0]);
      core.wr(`PFT_OFS_LATCH, mem[i]);
      core.wr(`PFT_OFS_CMD, `PFT_CMD_WRITE);
    end
    core.rd(`PFT_OFS_IRQ_STAT, 8'h00);
    // go without the keys only sets enable and select
    core.wr(`PFT_OFS_CTRL, 8'h85);
    core.rd(`PFT_OFS_CTRL, 8'h84);
    // protected pointer: go cleared, error flagged, nothing else
    long_write();
    core.rd(`PFT_OFS_CTRL, 8'h8c);
    core.idle();
    check({7'h00, irq}, 8'h01);
    core.rd(`PFT_OFS_IRQ_STAT, 8'h02);
    core.idle();
    #1;
    check({7'h00, irq}, 8'h00);
    // unprotect and program the same held block
    core.wr(`PFT_OFS_PROT, 8'h00);
    core.wr(`PFT_OFS_CTRL, 8'h84);
    core.wr(8'h30, 8'hff);
    long_write();
    check({7'h00, irq}, 8'h01);
    core.rd(`PFT_OFS_CTRL, 8'h84);
    core.rd(`PFT_OFS_IRQ_STAT, 8'h01);
    // read every byte back, even and odd addresses alike
    for (i = 0; i < 64; i++) begin
      core.wr(`PFT_OFS_PTR_LO, 8'h40 + i[7:0]);
      core.wr(`PFT_OFS_CMD, `PFT_CMD_READ);
      core.rd(`PFT_OFS_LATCH, mem[i]);
    end
    // no loads since completion: next block programs from all-ones latches
    core.wr(`PFT_OFS_IRQ_MASK, 8'h00);
    set_ptr(22'h000080);
    long_write();
    check({7'h00, irq}, 8'h00);
    core.rd(`PFT_OFS_IRQ_STAT, 8'h01);
    core.wr(`PFT_OFS_PTR_LO, 8'hbf);
    core.wr(`PFT_OFS_CMD, `PFT_CMD_READ);
    core.rd(`PFT_OFS_LATCH, 8'hff);
    core.idle();
    core.idle();
    end_sim();
  end
endmodule
`default_nettype wire
